// >>> design/cdbt_match.sv
/*
  cdbt_match: address, data and program counter comparators.
  assumes: core observation and breakpoint values on the core clock;
  purely combinational, the caller registers what it needs.
*/
`timescale 1ns/1ps
module cdbt_match (
  input  wire cdbt_pkg::cdbt_core_type core_i,
  input  wire logic [31:0]             addr_lo_i,
  input  wire logic [31:0]             addr_hi_i,
  input  wire logic [31:0]             data_i,
  input  wire logic [31:0]             dmask_i,
  input  wire logic [31:0]             pc_i,
  input  wire logic [31:0]             pcmask_i,
  input  wire logic                    qual_i,
  output cdbt_pkg::cdbt_hit_type       hit_o
);
  import cdbt_pkg::*;

  logic in_range;
  logic data_ok;

  // the two address registers bound an inclusive window
  assign in_range = (core_i.mem_addr >= addr_lo_i) && (core_i.mem_addr <= addr_hi_i);
  assign data_ok  = masked_eq(core_i.mem_data, data_i, dmask_i);

  // data compare optionally qualifies the address hit
  assign hit_o.addr_hit = core_i.mem_valid && in_range && (!qual_i || data_ok);
  assign hit_o.pc_hit   = core_i.insn_valid && masked_eq(core_i.pc, pc_i, pcmask_i);

endmodule // cdbt_match

// >>> design/cdbt_pkg.sv
/*
  cdbt_pkg: shared constants, types and helpers for the core debug
  breakpoint and trace block.
  assumes: included before every cdbt module; no state of its own.
*/
package cdbt_pkg;

  // register indices, shared by serial channel and supervisor port
  localparam logic [3:0] IDX_ADDR_LO = 4'h0;
  localparam logic [3:0] IDX_ADDR_HI = 4'h1;
  localparam logic [3:0] IDX_DATA    = 4'h2;
  localparam logic [3:0] IDX_DMASK   = 4'h3;
  localparam logic [3:0] IDX_PC      = 4'h4;
  localparam logic [3:0] IDX_PCMASK  = 4'h5;
  localparam logic [3:0] IDX_CFG     = 4'h6;
  localparam logic [3:0] IDX_STAT    = 4'h7;
  localparam int unsigned REG_WR_NUM = 7;

  // reset values
  localparam logic [31:0] REG_RST = 32'h0000_0000;

  // configuration field positions
  localparam int unsigned CFG_EN    = 0;
  localparam int unsigned CFG_DUAL  = 1;
  localparam int unsigned CFG_IRQ   = 2;
  localparam int unsigned CFG_QUAL  = 3;
  localparam int unsigned CFG_L1    = 4;
  localparam int unsigned CFG_L2    = 6;
  localparam int unsigned CFG_TRACE = 8;

  // serial frame: 4 bit command, 4 bit index, 32 bit data, msb first
  localparam logic [5:0] FRAME_LAST = 6'h27;
  localparam logic [5:0] CNT_RST    = 6'h00;

  // trace nibble counter
  localparam logic [2:0] NIB_LAST = 3'h7;
  localparam logic [2:0] NIB_RST  = 3'h0;

  // processor status codes on the trace bus
  localparam logic [3:0] TRC_IDLE   = 4'h0;
  localparam logic [3:0] TRC_INSN   = 4'h1;
  localparam logic [3:0] TRC_BRANCH = 4'h5;
  localparam logic [3:0] TRC_DATA   = 4'h8;
  localparam logic [3:0] TRC_TRIG   = 4'he;
  localparam logic [3:0] TRC_HALT   = 4'hf;

  typedef enum logic [3:0] {
    CMD_NOP   = 4'b0000,
    CMD_WRITE = 4'b0001,
    CMD_READ  = 4'b0010,
    CMD_HALT  = 4'b0011,
    CMD_GO    = 4'b0100
  } cdbt_cmd_type;

  typedef enum logic [1:0] {
    SRC_ADDR   = 2'b00,
    SRC_PC     = 2'b01,
    SRC_EITHER = 2'b10,
    SRC_BOTH   = 2'b11
  } cdbt_src_type;

  typedef enum logic [1:0] {
    TRG_ARMED  = 2'b00,
    TRG_LEVEL2 = 2'b01,
    TRG_FIRED  = 2'b10
  } cdbt_trig_type;

  typedef struct packed {
    logic        insn_valid;
    logic [31:0] pc;
    logic        branch_taken;
    logic [31:0] branch_target;
    logic        mem_valid;
    logic [31:0] mem_addr;
    logic [31:0] mem_data;
  } cdbt_core_type;

  typedef struct packed {
    logic addr_hit;
    logic pc_hit;
  } cdbt_hit_type;

  // a set mask bit means the position is ignored
  function automatic logic masked_eq(input logic [31:0] a, input logic [31:0] b,
                                     input logic [31:0] mask);
    masked_eq = ((a ^ b) & ~mask) == 32'h0000_0000;
  endfunction

endpackage

// >>> design/cdbt_top.sv
/*
  cdbt_top: breakpoint registers, trigger sequencer, halt and debug
  interrupt requests, serial debug channel and real-time trace port.
  assumes: core observation arrives on core_clk_i; the serial debug
  clock and data pins are asynchronous and are synchronised here.
*/
// How it works
// - six breakpoint registers: address, data, pc
// - registers reachable by serial tool and supervisor
// - combine comparisons into one- or two-level trigger
// - trigger halts core or raises debug interrupt
// - drive status, data nibbles and trace clock
// - halted debug mode while core is halted and halt requested
// - trace shows execution path in emulator mode
// - address hit optionally qualified by data compare
`timescale 1ns/1ps
module cdbt_top (
  input  wire logic                    core_clk_i,
  input  wire logic                    rstn_i,
  input  wire cdbt_pkg::cdbt_core_type core_i,
  input  wire logic                    core_halted_i,
  input  wire logic                    dsclk_i,
  input  wire logic                    dsi_i,
  output logic                         dso_o,
  input  wire logic                    sup_mode_i,
  input  wire logic                    sup_wr_i,
  input  wire logic                    sup_rd_i,
  input  wire logic [3:0]              sup_idx_i,
  input  wire logic [31:0]             sup_wdata_i,
  output logic [31:0]                  sup_rdata_o,
  output logic                         halt_req_o,
  output logic                         debug_irq_o,
  output logic                         halted_debug_mode_o,
  output logic [3:0]                   processor_status_trace_o,
  output logic [3:0]                   debug_trace_data_o,
  output logic                         trace_clock_out_o
);
  import cdbt_pkg::*;

  logic [31:0]   bp_reg [0:REG_WR_NUM-1];
  logic          dsclk_meta;
  logic          dsclk_s;
  logic          dsclk_d;
  logic          dsi_meta;
  logic          dsi_s;
  logic          ds_edge;
  logic [5:0]    bit_cnt;
  logic [38:0]   in_sh;
  logic [39:0]   next_frame;
  logic [31:0]   out_sh;
  logic          frame_done;
  cdbt_cmd_type  ser_cmd;
  logic [3:0]    ser_idx;
  logic          ser_wr;
  logic          ser_rd;
  logic          ser_halt;
  logic          ser_go;
  logic          sup_wr;
  logic          cfg_wr;
  cdbt_hit_type  hit;
  cdbt_trig_type trig_state;
  logic          l1_hit;
  logic          l2_hit;
  logic          fire;
  logic          rearm;
  logic [31:0]   cfg;
  logic          trace_en;
  logic [31:0]   nib_sh;
  logic [2:0]    nib_cnt;
  logic          nib_busy;

  // pick the comparison a trigger level listens to
  function automatic logic sel_hit(input logic [1:0] src, input cdbt_hit_type h);
    unique case (cdbt_src_type'(src))
      SRC_ADDR:   sel_hit = h.addr_hit;
      SRC_PC:     sel_hit = h.pc_hit;
      SRC_EITHER: sel_hit = h.addr_hit | h.pc_hit;
      SRC_BOTH:   sel_hit = h.addr_hit & h.pc_hit;
    endcase
  endfunction

  // register read, status word built from live state
  function automatic logic [31:0] read_reg(input logic [3:0] idx);
    if (idx == IDX_STAT) begin
      read_reg = {28'h0000000, halt_req_o, trig_state, core_halted_i};
    end else if (idx < IDX_STAT) begin
      read_reg = bp_reg[idx[2:0]];
    end else begin
      read_reg = 32'h0000_0000;
    end
  endfunction

  // two stage synchronisers for the serial pins
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      dsclk_meta <= 1'b0;
      dsclk_s    <= 1'b0;
      dsclk_d    <= 1'b0;
      dsi_meta   <= 1'b0;
      dsi_s      <= 1'b0;
    end else begin
      dsclk_meta <= dsclk_i;
      dsclk_s    <= dsclk_meta;
      dsclk_d    <= dsclk_s;
      dsi_meta   <= dsi_i;
      dsi_s      <= dsi_meta;
    end
  end

  // frame decode; the tool must hold each clock phase for 3+ core cycles
  assign ds_edge    = dsclk_s & ~dsclk_d;
  assign next_frame = {in_sh, dsi_s};
  assign frame_done = ds_edge && (bit_cnt == FRAME_LAST);
  assign ser_cmd    = cdbt_cmd_type'(next_frame[39:36]);
  assign ser_idx    = next_frame[35:32];
  assign ser_wr     = frame_done && (ser_cmd == CMD_WRITE);
  assign ser_rd     = frame_done && (ser_cmd == CMD_READ);
  assign ser_halt   = frame_done && (ser_cmd == CMD_HALT);
  assign ser_go     = frame_done && (ser_cmd == CMD_GO);
  // supervisor access only from supervisor mode; serial wins a collision
  assign sup_wr     = sup_wr_i && sup_mode_i && !ser_wr;
  assign cfg_wr     = (ser_wr && ser_idx == IDX_CFG) || (sup_wr && sup_idx_i == IDX_CFG);

  // serial shift in, bit count and read-back shift out
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      bit_cnt <= CNT_RST;
      in_sh   <= 39'h0;
      out_sh  <= REG_RST;
    end else if (ds_edge) begin
      in_sh   <= next_frame[38:0];
      bit_cnt <= frame_done ? CNT_RST : bit_cnt + 6'h01;
      out_sh  <= ser_rd ? read_reg(ser_idx) : {out_sh[30:0], 1'b0};
    end
  end

  // serial data out, read data leaves during the next frame
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      dso_o <= 1'b0;
    end else begin
      dso_o <= out_sh[31];
    end
  end

  // breakpoint register file; index 7 is status and read only
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int i = 0; i < REG_WR_NUM; i++) begin
        bp_reg[i] <= REG_RST;
      end
    end else if (ser_wr && ser_idx < IDX_STAT) begin
      bp_reg[ser_idx[2:0]] <= next_frame[31:0];
    end else if (sup_wr && sup_idx_i < IDX_STAT) begin
      bp_reg[sup_idx_i[2:0]] <= sup_wdata_i;
    end
  end

  // supervisor read data; refused reads return zero
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sup_rdata_o <= REG_RST;
    end else if (sup_rd_i) begin
      sup_rdata_o <= sup_mode_i ? read_reg(sup_idx_i) : 32'h0000_0000;
    end
  end

  assign cfg      = bp_reg[IDX_CFG[2:0]];
  assign trace_en = cfg[CFG_TRACE];

  cdbt_match u_match (
    .core_i    (core_i),
    .addr_lo_i (bp_reg[IDX_ADDR_LO[2:0]]),
    .addr_hi_i (bp_reg[IDX_ADDR_HI[2:0]]),
    .data_i    (bp_reg[IDX_DATA[2:0]]),
    .dmask_i   (bp_reg[IDX_DMASK[2:0]]),
    .pc_i      (bp_reg[IDX_PC[2:0]]),
    .pcmask_i  (bp_reg[IDX_PCMASK[2:0]]),
    .qual_i    (cfg[CFG_QUAL]),
    .hit_o     (hit)
  );

  // trigger levels from selected comparisons
  assign l1_hit = sel_hit(cfg[CFG_L1+1:CFG_L1], hit);
  assign l2_hit = sel_hit(cfg[CFG_L2+1:CFG_L2], hit);
  assign fire   = cfg[CFG_EN] && ((trig_state == TRG_ARMED && l1_hit && !cfg[CFG_DUAL]) ||
                                  (trig_state == TRG_LEVEL2 && l2_hit));
  assign rearm  = cfg_wr || ser_go;

  // trigger sequencer; a fire in the rearm cycle is kept
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      trig_state <= TRG_ARMED;
    end else if (fire) begin
      trig_state <= TRG_FIRED;
    end else if (rearm) begin
      trig_state <= TRG_ARMED;
    end else if (trig_state == TRG_ARMED && cfg[CFG_EN] && cfg[CFG_DUAL] && l1_hit) begin
      trig_state <= TRG_LEVEL2;
    end
  end

  // halt request holds until go; set beats a same-cycle go
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      halt_req_o <= 1'b0;
    end else if ((fire && !cfg[CFG_IRQ]) || ser_halt) begin
      halt_req_o <= 1'b1;
    end else if (ser_go) begin
      halt_req_o <= 1'b0;
    end
  end

  // interrupt pulse and halted mode flag
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      debug_irq_o         <= 1'b0;
      halted_debug_mode_o <= 1'b0;
    end else begin
      debug_irq_o         <= fire && cfg[CFG_IRQ];
      halted_debug_mode_o <= core_halted_i && halt_req_o;
    end
  end

  // status code; a new branch or operand overrides unsent nibbles
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      processor_status_trace_o <= TRC_IDLE;
      nib_sh                   <= REG_RST;
      nib_cnt                  <= NIB_RST;
      nib_busy                 <= 1'b0;
    end else if (!trace_en) begin
      processor_status_trace_o <= TRC_IDLE;
      nib_busy                 <= 1'b0;
    end else if (core_halted_i) begin
      processor_status_trace_o <= TRC_HALT;
      nib_busy                 <= 1'b0;
    end else if (fire) begin
      processor_status_trace_o <= TRC_TRIG;
      // keep the nibble stream moving, else a nibble would be sent twice
      nib_sh                   <= {4'h0, nib_sh[31:4]};
      nib_cnt                  <= nib_cnt + 3'h1;
      nib_busy                 <= nib_busy && (nib_cnt != NIB_LAST);
    end else if (core_i.branch_taken) begin
      processor_status_trace_o <= TRC_BRANCH;
      nib_sh                   <= core_i.branch_target;
      nib_cnt                  <= NIB_RST;
      nib_busy                 <= 1'b1;
    end else if (core_i.mem_valid) begin
      processor_status_trace_o <= TRC_DATA;
      nib_sh                   <= core_i.mem_data;
      nib_cnt                  <= NIB_RST;
      nib_busy                 <= 1'b1;
    end else begin
      processor_status_trace_o <= core_i.insn_valid ? TRC_INSN : TRC_IDLE;
      nib_sh                   <= {4'h0, nib_sh[31:4]};
      nib_cnt                  <= nib_cnt + 3'h1;
      nib_busy                 <= nib_busy && (nib_cnt != NIB_LAST);
    end
  end

  // data nibbles low first; trace clock toggles once per core cycle
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      debug_trace_data_o <= 4'h0;
      trace_clock_out_o  <= 1'b0;
    end else begin
      debug_trace_data_o <= (trace_en && !core_halted_i && core_i.branch_taken && !fire) ?
                            core_i.branch_target[3:0] :
                            ((trace_en && !core_halted_i && core_i.mem_valid && !fire) ?
                             core_i.mem_data[3:0] :
                             (nib_busy && trace_en ? nib_sh[7:4] : 4'h0));
      trace_clock_out_o  <= trace_en ? ~trace_clock_out_o : 1'b0;
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);

  halt_on_fire_a: assert property (fire && !cfg[CFG_IRQ] |=> halt_req_o)
    else $error("trigger with halt action did not halt");
  irq_on_fire_a: assert property (fire && cfg[CFG_IRQ] |=> debug_irq_o ##1 !debug_irq_o)
    else $error("debug interrupt not a single pulse after trigger");
  single_level_a: assert property (trig_state == TRG_ARMED && cfg[CFG_EN] && !cfg[CFG_DUAL]
    && l1_hit |=> trig_state == TRG_FIRED)
    else $error("single level trigger did not fire");
  dual_level_a: assert property (trig_state == TRG_ARMED && cfg[CFG_EN] && cfg[CFG_DUAL]
    && l1_hit |-> !fire ##1 trig_state == TRG_LEVEL2)
    else $error("dual level first stage mishandled");
  sup_write_a: assert property (sup_wr && sup_idx_i == IDX_PC |=>
    bp_reg[IDX_PC[2:0]] == $past(sup_wdata_i))
    else $error("supervisor write lost");
  halt_trace_a: assert property (trace_en && core_halted_i |=>
    processor_status_trace_o == TRC_HALT)
    else $error("halted status not shown");
  branch_trace_a: assert property (trace_en && !core_halted_i && !fire && core_i.branch_taken
    |=> processor_status_trace_o == TRC_BRANCH && debug_trace_data_o == $past(core_i.branch_target[3:0]))
    else $error("branch target not traced");
  halted_mode_a: assert property (core_halted_i && halt_req_o |=> halted_debug_mode_o)
    else $error("halted debug mode not entered");
  pc_mask_a: assert property (core_i.insn_valid && ((core_i.pc ^ bp_reg[IDX_PC[2:0]]) &
    ~bp_reg[IDX_PCMASK[2:0]]) == 32'h0 |-> hit.pc_hit)
    else $error("masked pc compare missed");
  addr_qual_a: assert property (hit.addr_hit && cfg[CFG_QUAL] |->
    core_i.mem_data == ((core_i.mem_data & bp_reg[IDX_DMASK[2:0]]) |
    (bp_reg[IDX_DATA[2:0]] & ~bp_reg[IDX_DMASK[2:0]])))
    else $error("address hit without data match");
  regs_reset_a: assert property ($rose(rstn_i) |-> bp_reg[IDX_CFG[2:0]] == REG_RST)
    else $error("config register not cleared by reset");

  dual_fire_c: cover property (trig_state == TRG_LEVEL2 ##[1:20] fire);
  irq_c: cover property (debug_irq_o);
  serial_write_c: cover property (ser_wr);
  branch_trace_c: cover property (trace_en && processor_status_trace_o == TRC_BRANCH);

endmodule // cdbt_top

// >>> verification/cdbt_tool_model.sv
/*
  cdbt_tool_model: behavioural external debug tool on the serial channel.
  assumes: runs on the core clock only for timing; the block synchronises
  the serial pins, so each clock level is held for four core cycles.
*/
`timescale 1ns/1ps
module cdbt_tool_model (
  input  wire logic core_clk_i,
  input  wire logic dso_i,
  output logic      dsclk_o,
  output logic      dsi_o
);
  import cdbt_pkg::*;

  localparam int unsigned HOLD = 4; // sync needs at least three cycles

  // serial clock stands low between frames
  initial begin
    dsclk_o = 1'b0;
    dsi_o   = 1'b0;
  end

  task automatic hold();
    repeat (HOLD) @(posedge core_clk_i);
    #1;
  endtask

  // one 40 bit frame msb first; rsp collects the answer to the previous frame
  task automatic frame(input logic [3:0] cmd, input logic [3:0] idx,
                       input logic [31:0] data, output logic [31:0] rsp);
    logic [39:0] bits;
    bits = {cmd, idx, data};
    rsp  = 32'h0000_0000;
    for (int k = 0; k < 40; k++) begin
      hold();
      dsclk_o = 1'b0;
      dsi_o   = bits[39-k];
      hold();
      if (k < 32) rsp[31-k] = dso_i;
      dsclk_o = 1'b1;
    end
    hold();
    dsclk_o = 1'b0;
    dsi_o   = ~dsi_o; // inverted line: last data bit not left standing
  endtask
endmodule // cdbt_tool_model

// >>> verification/tb_cdbt_top.sv
/*
  tb_cdbt_top: self-checking bench for the debug breakpoint and trace block.
  assumes: cdbt_pkg and cdbt_tool_model compiled first; 125 MHz core clock.
*/
`timescale 1ns/1ps
module tb_cdbt_top;
  import cdbt_pkg::*;

  logic          core_clk_i    = 1'b0;
  logic          rstn_i        = 1'b0;
  cdbt_core_type core_i        = '0;
  logic          core_halted_i = 1'b0;
  logic          sup_mode_i    = 1'b1;
  logic          sup_wr_i      = 1'b0;
  logic          sup_rd_i      = 1'b0;
  logic [3:0]    sup_idx_i     = 4'h0;
  logic [31:0]   sup_wdata_i   = 32'h0000_0000;
  logic          dsclk_i;
  logic          dsi_i;
  logic          dso_o;
  logic [31:0]   sup_rdata_o;
  logic          halt_req_o;
  logic          debug_irq_o;
  logic          halted_debug_mode_o;
  logic [3:0]    processor_status_trace_o;
  logic [3:0]    debug_trace_data_o;
  logic          trace_clock_out_o;
  int            err_count     = 0;
  int            check_count   = 0;
  logic [31:0]   got;

  always #4 core_clk_i = ~core_clk_i;

  cdbt_top i_cdbt_top (
    .core_clk_i(core_clk_i), .rstn_i(rstn_i), .core_i(core_i),
    .core_halted_i(core_halted_i), .dsclk_i(dsclk_i), .dsi_i(dsi_i), .dso_o(dso_o),
    .sup_mode_i(sup_mode_i), .sup_wr_i(sup_wr_i), .sup_rd_i(sup_rd_i),
    .sup_idx_i(sup_idx_i), .sup_wdata_i(sup_wdata_i), .sup_rdata_o(sup_rdata_o),
    .halt_req_o(halt_req_o), .debug_irq_o(debug_irq_o),
    .halted_debug_mode_o(halted_debug_mode_o),
    .processor_status_trace_o(processor_status_trace_o),
    .debug_trace_data_o(debug_trace_data_o), .trace_clock_out_o(trace_clock_out_o));

  cdbt_tool_model i_cdbt_tool_model (
    .core_clk_i(core_clk_i), .dso_i(dso_o), .dsclk_o(dsclk_i), .dsi_o(dsi_i));

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // every driver step lands one ns after a rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask

  task automatic sup_wr(input logic [3:0] idx, input logic [31:0] d);
    sup_wr_i    = 1'b1;
    sup_idx_i   = idx;
    sup_wdata_i = d;
    tick(1);
    sup_wr_i    = 1'b0;
    tick(1);
  endtask

  task automatic sup_rd(input logic [3:0] idx, output logic [31:0] d);
    sup_rd_i  = 1'b1;
    sup_idx_i = idx;
    tick(1);
    sup_rd_i  = 1'b0;
    d         = sup_rdata_o;
    tick(1);
  endtask

  // serial frame plus margin for the sync latency of the action
  task automatic ser(input logic [3:0] cmd, input logic [3:0] idx, input logic [31:0] d,
                     output logic [31:0] rsp);
    i_cdbt_tool_model.frame(cmd, idx, d, rsp);
    tick(4);
  endtask

  // one cycle of core activity; caller ticks before the next one
  task automatic core_cyc(input logic iv, input logic br, input logic mv,
                          input logic [31:0] a, input logic [31:0] d);
    core_i.insn_valid    = iv;
    core_i.pc            = a;
    core_i.branch_taken  = br;
    core_i.branch_target = a;
    core_i.mem_valid     = mv;
    core_i.mem_addr      = a;
    core_i.mem_data      = d;
    tick(1);
    core_i = '0;
  endtask

  // bounded wait, the level is judged where the wait ends
  task automatic wait_halt(input logic exp);
    for (int n = 0; n < 4 && halt_req_o !== exp; n++) tick(1);
    check("halt_req_o", {31'h0, exp}, {31'h0, halt_req_o});
  endtask

  task automatic irq_count(input int exp);
    int c;
    c = 0;
    for (int n = 0; n < 5; n++) begin
      if (debug_irq_o === 1'b1) c++;
      tick(1);
    end
    check("debug_irq_o pulses", exp, c);
  endtask

  task automatic t_regs();
    for (int i = 0; i < 8; i++) begin
      sup_rd(i[3:0], got);
      check("reset value", REG_RST, got);
    end
    for (int i = 0; i < 6; i++) sup_wr(i[3:0], 32'ha5a5_0f00 + 32'(i));
    for (int i = 0; i < 6; i++) begin
      sup_rd(i[3:0], got);
      check("breakpoint reg", 32'ha5a5_0f00 + 32'(i), got);
    end
    sup_wr(IDX_STAT, 32'hffff_ffff);
    sup_rd(IDX_STAT, got);
    check("status read only", 32'h0000_0000, got);
    sup_mode_i = 1'b0;
    sup_wr(IDX_DATA, 32'h0000_0000);
    sup_rd(IDX_DATA, got);
    check("user mode read", 32'h0000_0000, got);
    sup_mode_i = 1'b1;
    sup_rd(IDX_DATA, got);
    check("user mode write dropped", 32'ha5a5_0f02, got);
  endtask

  task automatic t_serial();
    ser(CMD_WRITE, IDX_PC, 32'hc0de_1234, got);
    sup_rd(IDX_PC, got);
    check("serial write", 32'hc0de_1234, got);
    sup_wr(IDX_ADDR_LO, 32'h1000_0000);
    sup_wr(IDX_ADDR_HI, 32'h1000_00ff);
    ser(CMD_READ, IDX_ADDR_HI, 32'h0000_0000, got);
    ser(CMD_NOP, 4'h0, 32'h0000_0000, got);
    check("serial read", 32'h1000_00ff, got);
  endtask

  task automatic t_halt();
    sup_wr(IDX_CFG, 32'h0000_0001);
    core_cyc(1'b0, 1'b0, 1'b1, 32'h1000_0100, 32'h0000_0000);
    tick(4);
    check("halt outside window", 32'h0, {31'h0, halt_req_o});
    core_cyc(1'b0, 1'b0, 1'b1, 32'h1000_00ff, 32'h0000_0000);
    wait_halt(1'b1);
    core_halted_i = 1'b1;
    tick(2);
    check("halted mode", 32'h1, {31'h0, halted_debug_mode_o});
    sup_rd(IDX_STAT, got);
    check("status fired", 32'h0000_000d, got);
    ser(CMD_READ, IDX_ADDR_LO, 32'h0000_0000, got);
    ser(CMD_GO, 4'h0, 32'h0000_0000, got);
    check("read while halted", 32'h1000_0000, got);
    wait_halt(1'b0);
    core_halted_i = 1'b0;
    tick(2);
    check("halted mode left", 32'h0, {31'h0, halted_debug_mode_o});
  endtask

  task automatic t_irq();
    sup_wr(IDX_DATA, 32'h0000_5a00);
    sup_wr(IDX_DMASK, 32'h0000_00ff);
    sup_wr(IDX_CFG, 32'h0000_000d);
    core_cyc(1'b0, 1'b0, 1'b1, 32'h1000_0010, 32'h0000_5b00);
    irq_count(0);
    core_cyc(1'b0, 1'b0, 1'b1, 32'h1000_0010, 32'h0000_5a3c);
    irq_count(1);
    check("no halt on irq action", 32'h0, {31'h0, halt_req_o});
  endtask

  task automatic t_dual();
    sup_wr(IDX_PC, 32'h0000_2000);
    sup_wr(IDX_PCMASK, 32'h0000_000f);
    sup_wr(IDX_CFG, 32'h0000_0043);
    core_cyc(1'b1, 1'b0, 1'b0, 32'h0000_2004, 32'h0000_0000);
    tick(4);
    check("level2 before level1", 32'h0, {31'h0, halt_req_o});
    core_cyc(1'b0, 1'b0, 1'b1, 32'h1000_0020, 32'h0000_0000);
    tick(4);
    sup_rd(IDX_STAT, got);
    check("second level armed", 32'h0000_0002, got);
    core_cyc(1'b1, 1'b0, 1'b0, 32'h0000_2010, 32'h0000_0000);
    tick(4);
    check("pc unmasked miss", 32'h0, {31'h0, halt_req_o});
    core_cyc(1'b1, 1'b0, 1'b0, 32'h0000_200b, 32'h0000_0000);
    wait_halt(1'b1);
    ser(CMD_GO, 4'h0, 32'h0000_0000, got);
    wait_halt(1'b0);
  endtask

  task automatic t_trace();
    logic prev;
    sup_wr(IDX_CFG, 32'h0000_0100);
    for (int n = 0; n < 4; n++) begin
      prev = trace_clock_out_o;
      tick(1);
      check("trace clock toggle", {31'h0, ~prev}, {31'h0, trace_clock_out_o});
    end
    core_cyc(1'b0, 1'b1, 1'b0, 32'h9876_5431, 32'h0000_0000);
    check("branch status", TRC_BRANCH, processor_status_trace_o);
    for (int k = 0; k < 8; k++) begin
      check("target nibble", (32'h9876_5431 >> (4 * k)) & 32'hf, debug_trace_data_o);
      tick(1);
    end
    core_cyc(1'b1, 1'b0, 1'b0, 32'h0000_0400, 32'h0000_0000);
    check("insn status", TRC_INSN, processor_status_trace_o);
    tick(1);
    core_cyc(1'b0, 1'b0, 1'b1, 32'h0000_0040, 32'h0000_00c7);
    check("operand status", TRC_DATA, processor_status_trace_o);
    check("operand nibble", 32'h7, debug_trace_data_o);
    sup_wr(IDX_CFG, 32'h0000_0000);
    tick(1);
    check("trace clock idle", 32'h0, {31'h0, trace_clock_out_o});
  endtask

  // both-source trigger, trigger and halted codes, halt by serial command
  task automatic t_status();
    sup_wr(IDX_PC, 32'h1000_0040);
    sup_wr(IDX_PCMASK, 32'h0000_0000);
    sup_wr(IDX_CFG, 32'h0000_0135);
    core_cyc(1'b1, 1'b0, 1'b0, 32'h1000_0040, 32'h0000_0000);
    check("pc alone status", TRC_INSN, processor_status_trace_o);
    irq_count(0);
    core_cyc(1'b1, 1'b0, 1'b1, 32'h1000_0040, 32'h0000_0000);
    check("trigger status", TRC_TRIG, processor_status_trace_o);
    irq_count(1);
    ser(CMD_HALT, 4'h0, 32'h0000_0000, got);
    wait_halt(1'b1);
    core_halted_i = 1'b1;
    tick(1);
    check("halted status", TRC_HALT, processor_status_trace_o);
    check("halted mode by command", 32'h1, {31'h0, halted_debug_mode_o});
    ser(CMD_GO, 4'h0, 32'h0000_0000, got);
    wait_halt(1'b0);
    core_halted_i = 1'b0;
    tick(2);
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // watchdog well beyond the roughly 23 us that the tests need
  initial begin
    #200us;
    err_count++;
    test_done();
  end

  initial begin
    tick(16);
    rstn_i = 1'b1;
    tick(1);
    check("status after reset", TRC_IDLE, processor_status_trace_o);
    check("halt after reset", 32'h0, {31'h0, halt_req_o});
    tick(2);
    t_regs();
    t_serial();
    t_halt();
    t_irq();
    t_dual();
    t_trace();
    t_status();
    test_done();
  end
endmodule // tb_cdbt_top
